/* src/sbf_consts.vh */
// register offsets, field positions, mode codes, tags and sizes of the batching queue
`ifndef SBF_CONSTS_VH
`define SBF_CONSTS_VH
`define SBF_OFF_EMB_EN 8'h05
`define SBF_OFF_WM_LOW 8'h07
`define SBF_OFF_WM_HIGH 8'h08
`define SBF_OFF_SRC_CFG 8'h09
`define SBF_OFF_MODE 8'h0a
`define SBF_OFF_CNT_HIGH 8'h0b
`define SBF_OFF_CNT_LOW 8'h0c
`define SBF_OFF_IRQ_A 8'h0d
`define SBF_OFF_IRQ_B 8'h0e
`define SBF_OFF_STAT_LOW 8'h3a
`define SBF_OFF_STAT_HIGH 8'h3b
`define SBF_OFF_TAG 8'h78
`define SBF_OFF_DATA0 8'h79
`define SBF_OFF_DATA5 8'h7e
// queue_mode_control fields
`define SBF_MODE_LSB 0
`define SBF_TS_DEC_LSB 6
`define SBF_TRIG_SEL_LSB 3
// watermark_high_and_options fields
`define SBF_WM_HI_BIT 0
`define SBF_RAW_RATE_LSB 1
`define SBF_META_BIT 4
`define SBF_COMPR_RT_BIT 6
`define SBF_STOP_WM_BIT 7
// embedded_func_enable_b
`define SBF_COMPR_FEAT_BIT 3
// batch_counter_cfg_high
`define SBF_CNT_SEL_BIT 5
// source config (own register)
`define SBF_SRC_STEP_BIT 0
`define SBF_SRC_HUB_BIT 1
`define SBF_SRC_EXT_IRQ_BIT 2
`define SBF_SRC_EXT_CNT_LSB 3
// routing bits in both irq routing registers
`define SBF_RT_TH_BIT 3
`define SBF_RT_FULL_BIT 5
`define SBF_RT_CNT_BIT 6
// status high bits
`define SBF_ST_CNT_BIT 4
`define SBF_ST_EMPTY_BIT 3
`define SBF_ST_FULL_BIT 5
`define SBF_ST_OVR_BIT 6
`define SBF_ST_WM_BIT 7
// modes
`define SBF_M_BYPASS 3'h0
`define SBF_M_FIFO 3'h1
`define SBF_M_C2F 3'h3
`define SBF_M_B2C 3'h4
`define SBF_M_CONT 3'h6
`define SBF_M_B2F 3'h7
// storage: 3 KB raw / 7-byte words = 438 words, addressable by 9 bits
`define SBF_DEPTH 10'h1b6
`define SBF_AW 9
`define SBF_WW 56
// tags
`define SBF_TAG_GYRO 8'h01
`define SBF_TAG_ACC 8'h02
`define SBF_TAG_TEMP 8'h03
`define SBF_TAG_TS 8'h04
`define SBF_TAG_CFG 8'h05
`define SBF_TAG_STEP 8'h12
`define SBF_TAG_EXT0 8'h0e
`define SBF_TAG_COMPR 8'h07
`endif

/* src/sbf_mem.v */
// word storage with registered read data
`timescale 1ns/10ps
`include "sbf_consts.vh"
module sbf_mem (
  input wire clk,
  input wire wr_en,
  input wire [`SBF_AW-1:0] wr_addr,
  input wire [`SBF_WW-1:0] wr_data,
  input wire [`SBF_AW-1:0] rd_addr,
  output reg [`SBF_WW-1:0] rd_data
);
  reg [`SBF_WW-1:0] mem [0:(1<<`SBF_AW)-1];
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* src/sbf_fifo.v */
// sensor batching queue: word store, modes, status, routing and wishbone registers
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
`include "sbf_consts.vh"
module sbf_fifo (
  input wire SYS_CLK,
  input wire RESET,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  input wire [3:0] WB_SEL_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  input wire ACC_READY,
  input wire GYRO_READY,
  input wire [47:0] ACC_SAMPLE,
  input wire [47:0] GYRO_SAMPLE,
  input wire HUB_READY,
  input wire [3:0] EXT_IRQ,
  input wire [191:0] EXT_SAMPLE,
  input wire STEP_DETECT,
  input wire [15:0] STEP_COUNT,
  input wire TEMP_READY,
  input wire [15:0] TEMP_SAMPLE,
  input wire [31:0] TIMESTAMP,
  input wire RATE_CHANGE,
  input wire [15:0] RATE_CONFIG,
  input wire [4:0] TRIGGER_EVENTS,
  output reg IRQ_PIN_A,
  output reg IRQ_PIN_B
);
  reg [7:0] emb_en_reg, wm_low_reg, wm_high_reg, src_cfg_reg, mode_reg;
  reg [7:0] cnt_high_reg, cnt_low_reg, irq_a_reg, irq_b_reg;
  reg [`SBF_AW-1:0] wr_ptr_reg, rd_ptr_reg;
  reg [9:0] count_reg;
  reg ovr_reg, cnt_flag_reg;
  reg [10:0] batch_cnt_reg;
  reg [4:0] ts_dec_reg;
  reg [4:0] raw_cnt_reg;
  reg [6:0] bytes_read_reg;
  reg [2:0] ext_idx_reg;
  reg [3:0] ext_pend_reg;
  reg [2:0] ts_seq_reg;
  reg [`SBF_WW-1:0] ts_word_reg;

  wire [2:0] mode = mode_reg[`SBF_MODE_LSB+2:`SBF_MODE_LSB];
  wire [8:0] watermark_level = {wm_high_reg[`SBF_WM_HI_BIT], wm_low_reg};
  wire stop_at_threshold = wm_high_reg[`SBF_STOP_WM_BIT];
  wire rate_change_meta_on = wm_high_reg[`SBF_META_BIT];
  wire compression_runtime_on = wm_high_reg[`SBF_COMPR_RT_BIT];
  wire compression_feature_on = emb_en_reg[`SBF_COMPR_FEAT_BIT];
  wire [1:0] raw_word_insert_rate = wm_high_reg[`SBF_RAW_RATE_LSB+1:`SBF_RAW_RATE_LSB];
  wire [10:0] batch_count_threshold = {cnt_high_reg[2:0], cnt_low_reg};
  wire batch_count_sensor_sel = cnt_high_reg[`SBF_CNT_SEL_BIT];
  wire [2:0] trig_sel = mode_reg[`SBF_TRIG_SEL_LSB+2:`SBF_TRIG_SEL_LSB];
  wire trig = (trig_sel < 3'h5) ? TRIGGER_EVENTS[trig_sel] : 1'b0;
  wire compress_on = compression_feature_on & compression_runtime_on;

  // effective operating behaviour from mode and trigger
  reg clear_q, store_en, stop_full;
  always @* begin
    clear_q = 1'b0;
    store_en = 1'b1;
    stop_full = 1'b0;
    case (mode)
      `SBF_M_BYPASS: begin
        clear_q = 1'b1;
        store_en = 1'b0;
      end
      `SBF_M_FIFO: stop_full = 1'b1;
      `SBF_M_CONT: stop_full = 1'b0;
      `SBF_M_C2F: stop_full = trig;
      `SBF_M_B2C: begin
        clear_q = ~trig;
        store_en = trig;
      end
      `SBF_M_B2F: begin
        clear_q = ~trig;
        store_en = trig;
        stop_full = 1'b1;
      end
      default: begin
        clear_q = 1'b1;
        store_en = 1'b0;
      end
    endcase
  end

  // stop-at-threshold shrinks the usable depth; zero watermark keeps full depth
  wire [9:0] eff_depth = (stop_at_threshold && watermark_level != 9'h000) ?
                         {1'b0, watermark_level} : `SBF_DEPTH;
  wire full = count_reg >= eff_depth;
  wire empty = count_reg == 10'h000;
  wire wm_flag = count_reg >= {1'b0, watermark_level};

  // source arbitration: one word per cycle; a lower-priority ready not taken is not held, except external sensor requests
  wire [3:0] ext_cnt_m1 = {2'b00, src_cfg_reg[`SBF_SRC_EXT_CNT_LSB+1:`SBF_SRC_EXT_CNT_LSB]};
  wire ext_on_irq = src_cfg_reg[`SBF_SRC_EXT_IRQ_BIT];
  wire ts_due = (ts_dec_reg == 5'h00);
  reg [`SBF_WW-1:0] in_word;
  reg in_valid, take_acc, take_gyro, take_temp, take_ext, take_ts, take_meta, take_step;
  reg [2:0] wait_sel;
  always @* begin
    in_word = {`SBF_WW{1'b0}};
    in_valid = 1'b0;
    take_acc = 1'b0;
    take_gyro = 1'b0;
    take_temp = 1'b0;
    take_ext = 1'b0;
    take_ts = 1'b0;
    take_meta = 1'b0;
    take_step = 1'b0;
    wait_sel = 3'h0;
    if (ts_seq_reg != 3'h0) begin
      in_valid = 1'b1;
      take_ts = 1'b1;
      in_word = ts_word_reg;
    end else if (RATE_CHANGE && rate_change_meta_on) begin
      in_valid = 1'b1;
      take_meta = 1'b1;
      in_word = {`SBF_TAG_CFG, RATE_CONFIG, TIMESTAMP};
    end else if (STEP_DETECT && src_cfg_reg[`SBF_SRC_STEP_BIT]) begin
      in_valid = 1'b1;
      take_step = 1'b1;
      in_word = {`SBF_TAG_STEP, STEP_COUNT, TIMESTAMP};
    end else if (GYRO_READY) begin
      in_valid = 1'b1;
      take_gyro = 1'b1;
      in_word = {(compress_on && raw_cnt_reg != 5'h00) ? `SBF_TAG_COMPR : `SBF_TAG_GYRO, GYRO_SAMPLE};
    end else if (ACC_READY) begin
      in_valid = 1'b1;
      take_acc = 1'b1;
      in_word = {(compress_on && raw_cnt_reg != 5'h00) ? `SBF_TAG_COMPR : `SBF_TAG_ACC, ACC_SAMPLE};
    end else if (ext_pend_reg != 4'h0) begin
      in_valid = 1'b1;
      take_ext = 1'b1;
      wait_sel = ext_idx_reg;
      in_word = {`SBF_TAG_EXT0 + {5'h00, ext_idx_reg}, EXT_SAMPLE[ext_idx_reg*48 +: 48]};
    end else if (TEMP_READY) begin
      in_valid = 1'b1;
      take_temp = 1'b1;
      in_word = {`SBF_TAG_TEMP, 32'h0000_0000, TEMP_SAMPLE};
    end
  end

  wire do_push = in_valid & store_en & ~clear_q & (~full | ~stop_full);
  wire overwrite = do_push & full & ~stop_full;

  // wishbone slave: one wait state, ack on second cycle of the request
  wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
  wire wb_rd = wb_req & ~WB_WE_I;
  wire [`SBF_WW-1:0] head_word;
  wire rd_tag = wb_rd && WB_ADR_I == `SBF_OFF_TAG;
  wire rd_data_byte = wb_rd && WB_ADR_I >= `SBF_OFF_DATA0 && WB_ADR_I <= `SBF_OFF_DATA5;
  wire [2:0] byte_idx = rd_tag ? 3'h0 : WB_ADR_I[2:0] - 3'h0;
  wire [6:0] bytes_now = bytes_read_reg | ((rd_tag | rd_data_byte) ? (7'h01 << byte_idx) : 7'h00);
  wire do_pop = !empty && (bytes_now == 7'h7f);
  wire pop_eff = do_pop & ~overwrite;

  sbf_mem u_mem (
    .clk(SYS_CLK),
    .wr_en(do_push),
    .wr_addr(wr_ptr_reg),
    .wr_data(in_word),
    .rd_addr(rd_ptr_reg),
    .rd_data(head_word)
  );

  function [`SBF_AW-1:0] ptr_inc;
    input [`SBF_AW-1:0] p;
    begin
      ptr_inc = (p == `SBF_DEPTH - 10'h001) ? {`SBF_AW{1'b0}} : p + 1'b1;
    end
  endfunction

  always @(posedge SYS_CLK) begin
    if (RESET || clear_q) begin
      wr_ptr_reg <= {`SBF_AW{1'b0}};
      rd_ptr_reg <= {`SBF_AW{1'b0}};
      count_reg <= 10'h000;
      ovr_reg <= 1'b0;
      bytes_read_reg <= 7'h00;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (overwrite | pop_eff) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      if (do_push & ~overwrite & ~do_pop) begin
        count_reg <= count_reg + 10'h001;
      end else if (~do_push & do_pop) begin
        count_reg <= count_reg - 10'h001;
      end
      if (overwrite) begin
        ovr_reg <= 1'b1;
      end
      // head changes under the reader on overwrite, so restart its byte tally
      // empty queue keeps no tally, so early reads cannot pop a later word
      if (do_pop | overwrite | empty) begin
        bytes_read_reg <= 7'h00;
      end else begin
        bytes_read_reg <= bytes_now;
      end
    end
  end

  // timestamp, decimation, compression raw insert, external pending, batch counter
  wire [5:0] ts_div = (mode_reg[`SBF_TS_DEC_LSB+1:`SBF_TS_DEC_LSB] == 2'h1) ? 6'h08 :
                      (mode_reg[`SBF_TS_DEC_LSB+1:`SBF_TS_DEC_LSB] == 2'h2) ? 6'h20 : 6'h01;
  wire data_word = take_acc | take_gyro;
  wire ts_enabled = mode_reg[`SBF_TS_DEC_LSB+1:`SBF_TS_DEC_LSB] != 2'h0;
  wire [3:0] ext_trig = ext_on_irq ? EXT_IRQ : {4{ACC_READY & HUB_READY}};
  wire [3:0] ext_mask = (4'h2 << ext_cnt_m1[1:0]) - 4'h1;
  wire [3:0] ext_left = (ext_pend_reg | ext_trig) & ext_mask & ~(take_ext ? (4'h1 << wait_sel[1:0]) : 4'h0);
  wire [4:0] raw_period_m1 = (raw_word_insert_rate == 2'h1) ? 5'h07 :
                             (raw_word_insert_rate == 2'h2) ? 5'h0f : 5'h1f;
  wire batch_evt = batch_count_sensor_sel ? take_gyro : take_acc;
  integer i;
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      ts_dec_reg <= 5'h00;
      ts_seq_reg <= 3'h0;
      ts_word_reg <= {`SBF_WW{1'b0}};
      raw_cnt_reg <= 5'h00;
      ext_pend_reg <= 4'h0;
      ext_idx_reg <= 3'h0;
      batch_cnt_reg <= 11'h000;
      cnt_flag_reg <= 1'b0;
    end else begin
      ts_seq_reg <= 3'h0;
      if (data_word && ts_enabled) begin
        ts_dec_reg <= ts_due ? (ts_div[4:0] - 5'h01) : ts_dec_reg - 5'h01;
        if (ts_due) begin
          ts_seq_reg <= 3'h1;
          ts_word_reg <= {`SBF_TAG_TS, 16'h0000, TIMESTAMP};
        end
      end
      if (data_word && compress_on) begin
        // raw word forced every 8, 16 or 32 words; rate 0 forces only the first, while the count still holds its reset 0
        raw_cnt_reg <= (raw_word_insert_rate == 2'h0) ? 5'h01 :
                       (raw_cnt_reg >= raw_period_m1) ? 5'h00 : raw_cnt_reg + 5'h01;
      end
      // the sensor taken now is left out, so it is not written twice
      ext_pend_reg <= ext_left;
      ext_idx_reg <= 3'h0;
      for (i = 3; i >= 0; i = i - 1) begin
        if (ext_left[i]) begin
          ext_idx_reg <= i[2:0];
        end
      end
      // read clear first, so a threshold hit in the same cycle wins
      if (wb_rd && WB_ADR_I == `SBF_OFF_STAT_HIGH) begin
        cnt_flag_reg <= 1'b0;
      end
      if (batch_evt && do_push) begin
        if (batch_cnt_reg + 11'h001 >= batch_count_threshold && batch_count_threshold != 11'h000) begin
          batch_cnt_reg <= 11'h000;
          cnt_flag_reg <= 1'b1;
        end else begin
          batch_cnt_reg <= batch_cnt_reg + 11'h001;
        end
      end
    end
  end

  wire [7:0] status_high = {wm_flag, ovr_reg, full, cnt_flag_reg, empty, 1'b0, count_reg[9:8]};

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      emb_en_reg <= 8'h00;
      wm_low_reg <= 8'h00;
      wm_high_reg <= 8'h00;
      src_cfg_reg <= 8'h00;
      mode_reg <= 8'h00;
      cnt_high_reg <= 8'h00;
      cnt_low_reg <= 8'h00;
      irq_a_reg <= 8'h00;
      irq_b_reg <= 8'h00;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      IRQ_PIN_A <= 1'b0;
      IRQ_PIN_B <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_wr) begin
        case (WB_ADR_I)
          `SBF_OFF_EMB_EN: emb_en_reg <= WB_DAT_I[7:0];
          `SBF_OFF_WM_LOW: wm_low_reg <= WB_DAT_I[7:0];
          `SBF_OFF_WM_HIGH: wm_high_reg <= WB_DAT_I[7:0];
          `SBF_OFF_SRC_CFG: src_cfg_reg <= WB_DAT_I[7:0];
          `SBF_OFF_MODE: mode_reg <= WB_DAT_I[7:0];
          `SBF_OFF_CNT_HIGH: cnt_high_reg <= WB_DAT_I[7:0];
          `SBF_OFF_CNT_LOW: cnt_low_reg <= WB_DAT_I[7:0];
          `SBF_OFF_IRQ_A: irq_a_reg <= WB_DAT_I[7:0];
          `SBF_OFF_IRQ_B: irq_b_reg <= WB_DAT_I[7:0];
          default: ;
        endcase
      end
      WB_DAT_O <= 32'h0000_0000;
      if (wb_rd) begin
        case (WB_ADR_I)
          `SBF_OFF_EMB_EN: WB_DAT_O[7:0] <= emb_en_reg;
          `SBF_OFF_WM_LOW: WB_DAT_O[7:0] <= wm_low_reg;
          `SBF_OFF_WM_HIGH: WB_DAT_O[7:0] <= wm_high_reg;
          `SBF_OFF_SRC_CFG: WB_DAT_O[7:0] <= src_cfg_reg;
          `SBF_OFF_MODE: WB_DAT_O[7:0] <= mode_reg;
          `SBF_OFF_CNT_HIGH: WB_DAT_O[7:0] <= cnt_high_reg;
          `SBF_OFF_CNT_LOW: WB_DAT_O[7:0] <= cnt_low_reg;
          `SBF_OFF_IRQ_A: WB_DAT_O[7:0] <= irq_a_reg;
          `SBF_OFF_IRQ_B: WB_DAT_O[7:0] <= irq_b_reg;
          `SBF_OFF_STAT_LOW: WB_DAT_O[7:0] <= count_reg[7:0];
          `SBF_OFF_STAT_HIGH: WB_DAT_O[7:0] <= status_high;
          `SBF_OFF_TAG: WB_DAT_O[7:0] <= empty ? 8'h00 : head_word[55:48];
          default: begin
            if (rd_data_byte && !empty) begin
              WB_DAT_O[7:0] <= head_word[(WB_ADR_I[2:0]-3'h1)*8 +: 8];
            end
          end
        endcase
      end
      IRQ_PIN_A <= (irq_a_reg[`SBF_RT_TH_BIT] & wm_flag) | (irq_a_reg[`SBF_RT_FULL_BIT] & full) |
                   (irq_a_reg[`SBF_RT_CNT_BIT] & cnt_flag_reg);
      IRQ_PIN_B <= (irq_b_reg[`SBF_RT_TH_BIT] & wm_flag) | (irq_b_reg[`SBF_RT_FULL_BIT] & full) |
                   (irq_b_reg[`SBF_RT_CNT_BIT] & cnt_flag_reg);
    end
  end
endmodule

/* sim/sbf_fifo_sva.sv */
// bus and interrupt pin assertions for the batching queue
`timescale 1ns/10ps
module sbf_fifo_chk (
  input wire SYS_CLK,
  input wire RESET,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  input wire IRQ_PIN_A,
  input wire IRQ_PIN_B
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  reg [2:0] mode_reg;
  reg [2:0] route_reg;
  wire wr_done = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && WB_ACK_O;
  wire rd_done = WB_ACK_O && !WB_WE_I;
  // shadow lags the design by one edge, so it only ever makes checks later
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      mode_reg <= 3'h0;
      route_reg <= 3'h0;
    end else if (wr_done && WB_ADR_I == 8'h0a) begin
      mode_reg <= WB_DAT_I[2:0];
    end else if (wr_done && WB_ADR_I == 8'h0d) begin
      route_reg <= {WB_DAT_I[6:5], WB_DAT_I[3]};
    end
  end
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_ack_latency: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered next cycle");
  chk_idle_data: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  chk_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_unmapped_zero: assert property (rd_done && WB_ADR_I == 8'hff |-> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  chk_bypass_count: assert property (rd_done && WB_ADR_I == 8'h3a && mode_reg == 3'h0 |-> WB_DAT_O[7:0] == 8'h0)
    else $error("count not zero in bypass");
  chk_bypass_status: assert property (rd_done && WB_ADR_I == 8'h3b && mode_reg == 3'h0 |->
    WB_DAT_O[3] && WB_DAT_O[6:5] == 2'h0 && WB_DAT_O[1:0] == 2'h0)
    else $error("status not empty in bypass");
  chk_irq_unrouted: assert property (route_reg == 3'h0 && $past(route_reg) == 3'h0 |-> !IRQ_PIN_A)
    else $error("pin a high with no route");
  cov_full: cover property (rd_done && WB_ADR_I == 8'h3b && WB_DAT_O[5]);
  cov_ovr: cover property (rd_done && WB_ADR_I == 8'h3b && WB_DAT_O[6]);
  cov_pin_b: cover property ($rose(IRQ_PIN_B));
endmodule
bind sbf_fifo sbf_fifo_chk chk_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .IRQ_PIN_A(IRQ_PIN_A), .IRQ_PIN_B(IRQ_PIN_B));

/* sim/sbf_sensor_model.sv */
// sensor side: pulses accel ready with numbered samples
`timescale 1ns/10ps
module sbf_sensor_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic slow,
  input wire logic [9:0] n_req,
  input wire logic [31:0] base,
  output logic busy,
  output logic rdy,
  output logic [47:0] smp
);
  logic [9:0] left_reg;
  logic [15:0] seq_reg;
  logic [1:0] gap_reg;
  always @(posedge clk) begin
    rdy <= 1'b0;
    smp <= ~smp; // idle data inverts every cycle, so a capture one cycle late never passes
    if (rst) begin
      busy <= 1'b0;
      smp <= 48'h0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      left_reg <= n_req;
      seq_reg <= 16'h0;
      gap_reg <= 2'h0;
    end else if (busy && gap_reg != 2'h0) begin
      gap_reg <= gap_reg - 2'h1;
    end else if (busy && left_reg == 10'h0) begin
      busy <= 1'b0;
    end else if (busy) begin
      rdy <= 1'b1;
      smp <= {base, seq_reg};
      seq_reg <= seq_reg + 16'h1;
      left_reg <= left_reg - 10'h1;
      gap_reg <= slow ? 2'h3 : 2'h1;
    end
  end
endmodule

/* sim/testbench.sv */
// self-checking bench for the batching queue
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack, irq_a, irq_b, rdy, busy;
  logic [47:0] smp;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic [9:0] n_req = 10'h0;
  logic [31:0] base = 32'h0;
  logic [31:0] ts = 32'h0;
  logic [4:0] trig = 5'h0;
  logic step = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [31:0] rng = 32'h0000e827;
  int num_errors = 0;
  int compares = 0;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  logic [7:0] offs[7] = '{8'h07, 8'h08, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h05};
  logic [7:0] masks[7] = '{8'hff, 8'hd7, 8'h27, 8'hff, 8'h68, 8'h68, 8'h08};
  always #2.5 clk = ~clk;
  always @(posedge clk) ts <= ts + 32'h1;
  sbf_fifo uut (.SYS_CLK(clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_DAT_I(dat), .WB_SEL_I(sel), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .ACC_READY(rdy), .GYRO_READY(1'b0),
    .ACC_SAMPLE(smp), .GYRO_SAMPLE({base, ts[15:0]}), .HUB_READY(1'b0), .EXT_IRQ(4'h0),
    .EXT_SAMPLE({6{base}}), .STEP_DETECT(step), .STEP_COUNT(ts[15:0]), .TEMP_READY(1'b0),
    .TEMP_SAMPLE(base[15:0]), .TIMESTAMP(ts), .RATE_CHANGE(1'b0), .RATE_CONFIG(base[31:16]),
    .TRIGGER_EVENTS(trig), .IRQ_PIN_A(irq_a), .IRQ_PIN_B(irq_b));
  sbf_sensor_model sensor (.clk(clk), .rst(reset), .start(start), .slow(slow), .n_req(n_req), .base(base),
    .busy(busy), .rdy(rdy), .smp(smp));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) num_errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb(a, 1'b0, 8'h0);
  endtask
  task automatic push(input int n, input logic s);
    rng = xs(rng);
    base <= rng;
    n_req <= n[9:0];
    slow <= s;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
  endtask
  // tag first, then the six sample bytes, low byte first
  task automatic rd_bytes(input logic [15:0] seq, input int lo, input int hi);
    logic [47:0] w;
    w = {base, seq};
    for (int i = lo; i <= hi; i++) rd(8'h78 + i[7:0], i == 0 ? 8'h02 : w[8 * (i - 1) +: 8], 8'hff);
  endtask
  task automatic wait_pins(input logic [1:0] e);
    for (int i = 0; i < 8 && {irq_a, irq_b} !== e; i++) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      check($sformatf("offset %h", adr), dat_o & {24'hffffff, msk_q.pop_front()}, {24'h0, exp_q.pop_front()});
  end
  initial begin
    repeat (50000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end
  initial begin
    logic [7:0] md;
    logic [47:0] stp_w;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) rd(offs[i], 8'h0, 8'hff);
    rd(8'h3a, 8'h0, 8'hff);
    for (int i = 0; i < 7; i++) begin
      rng = xs(rng);
      wr(offs[i], rng[7:0]);
      rd(offs[i], rng[7:0] & masks[i], masks[i]);
      wr(offs[i], 8'h0);
    end
    wr(8'hff, 8'h5a);
    rd(8'hff, 8'h0, 8'hff);
    wr(8'h3a, 8'h5a);
    rd(8'h3a, 8'h0, 8'hff);
    // a write without the low byte lane selected must not land
    sel <= 4'he;
    wr(8'h0c, 8'h5a);
    sel <= 4'hf;
    rd(8'h0c, 8'h0, 8'hff);
    wr(8'h0c, 8'h02);
    wr(8'h0d, 8'h40);
    wr(8'h0a, 8'h06);
    push(2, 1'b0);
    wait_pins(2'h2);
    check("pins", {30'h0, irq_a, irq_b}, 32'h2);
    rd(8'h3b, 8'h10, 8'h10);
    rd(8'h3b, 8'h00, 8'h10);
    wr(8'h0d, 8'h0);
    wr(8'h0c, 8'h0);
    wr(8'h0a, 8'h0);
    wr(8'h07, 8'h04);
    wr(8'h0a, 8'h01);
    push(5, 1'b0);
    rd(8'h3a, 8'h05, 8'hff);
    rd(8'h3b, 8'h80, 8'heb);
    rd_bytes(16'h0, 0, 5);
    rd(8'h3a, 8'h05, 8'hff);
    rd_bytes(16'h0, 6, 6);
    rd(8'h3a, 8'h04, 8'hff);
    rd(8'h3b, 8'h80, 8'heb);
    rd_bytes(16'h1, 0, 6);
    rd(8'h3b, 8'h00, 8'heb);
    wr(8'h0a, 8'h0);
    rd(8'h3b, 8'h08, 8'heb);
    wr(8'h07, 8'h03);
    wr(8'h08, 8'h80);
    wr(8'h0a, 8'h01);
    push(6, 1'b1);
    rd(8'h3a, 8'h03, 8'hff);
    wr(8'h0a, 8'h0);
    wr(8'h07, 8'hff);
    wr(8'h08, 8'h01);
    wr(8'h0a, 8'h01);
    push(440, 1'b0);
    rd(8'h3a, 8'hb6, 8'hff);
    rd(8'h3b, 8'h21, 8'heb);
    wr(8'h0a, 8'h06);
    push(2, 1'b0);
    rd(8'h3b, 8'h61, 8'heb);
    wr(8'h0d, 8'h20);
    wait_pins(2'h2);
    check("pins", {30'h0, irq_a, irq_b}, 32'h2);
    wr(8'h0e, 8'h20);
    wr(8'h0d, 8'h0);
    wait_pins(2'h1);
    check("pins", {30'h0, irq_a, irq_b}, 32'h1);
    wr(8'h0e, 8'h0);
    wr(8'h0a, 8'h0);
    rd(8'h3b, 8'h08, 8'heb);
    // trigger selects 0 to 4, with the other trigger lines set against it
    for (int s = 0; s < 5; s++) for (int m = 0; m < 3; m++) for (int t = 0; t < 2; t++) begin
      md = {2'b00, s[2:0], m == 0 ? 3'h3 : m == 1 ? 3'h4 : 3'h7};
      trig <= t ? 5'h1 << s : ~(5'h1 << s);
      wr(8'h0a, md);
      push(2, 1'b0);
      rd(8'h3a, (m == 0 || t == 1) ? 8'h02 : 8'h00, 8'hff);
      wr(8'h0a, 8'h0);
    end
    // one step pulse: step count and timestamp as seen at the sampling edge
    wr(8'h09, 8'h01);
    wr(8'h0a, 8'h06);
    step <= 1'b1;
    @(posedge clk);
    stp_w = {ts[15:0], ts};
    step <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) rd(8'h78 + i[7:0], i == 0 ? 8'h12 : stp_w[8 * (i - 1) +: 8], 8'hff);
    // compression on with rate 0: first word raw, later ones compressed
    wr(8'h05, 8'h08);
    wr(8'h08, 8'h40);
    push(2, 1'b0);
    rd_bytes(16'h0, 0, 6);
    rd(8'h78, 8'h07, 8'hff);
    report_and_stop;
  end
endmodule
